// [hw/gpio_line_pkg.sv]
package gpio_line_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_OUTPUT_ENABLE_CMD = 8'h10;
  localparam logic [7:0] OFF_OUTPUT_DISABLE_CMD = 8'h14;
  localparam logic [7:0] OFF_OUTPUT_ENABLE_STATUS = 8'h18;
  localparam logic [7:0] OFF_FILTER_ENABLE_CMD = 8'h20;
  localparam logic [7:0] OFF_FILTER_DISABLE_CMD = 8'h24;
  localparam logic [7:0] OFF_FILTER_STATUS = 8'h28;
  localparam logic [7:0] OFF_SET_OUTPUT_DATA_CMD = 8'h30;
  localparam logic [7:0] OFF_CLEAR_OUTPUT_DATA_CMD = 8'h34;
  localparam logic [7:0] OFF_OUTPUT_DATA_STATUS = 8'h38;
  localparam logic [7:0] OFF_PIN_LEVEL_STATUS = 8'h3c;
  localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE_CMD = 8'h40;
  localparam logic [7:0] OFF_CHANGE_IRQ_DISABLE_CMD = 8'h44;
  localparam logic [7:0] OFF_CHANGE_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFF_CHANGE_IRQ_STATUS = 8'h4c;
  localparam logic [7:0] OFF_OPEN_DRAIN_ENABLE_CMD = 8'h50;
  localparam logic [7:0] OFF_OPEN_DRAIN_DISABLE_CMD = 8'h54;
  localparam logic [7:0] OFF_OPEN_DRAIN_STATUS = 8'h58;
  localparam logic [7:0] OFF_OUTPUT_WRITE_ENABLE_CMD = 8'ha0;
  localparam logic [7:0] OFF_OUTPUT_WRITE_DISABLE_CMD = 8'ha4;
  localparam logic [7:0] OFF_OUTPUT_WRITE_PERMISSION = 8'ha8;

  // Reset values
  localparam logic [31:0] RST_OUTPUT_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_FILTER = 32'h0000_0000;
  localparam logic [31:0] RST_OUTPUT_DATA = 32'h0000_0000;
  localparam logic [31:0] RST_PIN_LEVEL = 32'h0000_0000;
  localparam logic [31:0] RST_CHANGE_IRQ_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_CHANGE_IRQ_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_OPEN_DRAIN = 32'h0000_0000;
  localparam logic [31:0] RST_OUTPUT_WRITE = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // Timing: glitch filter stable-sample count
  localparam int FILTER_CYCLES_DEFAULT = 2;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// [hw/line_input_stage.sv]
`timescale 1ns/1ps
module line_input_stage
  import gpio_line_pkg::*;
#(
  parameter int LINES = 32,
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEFAULT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [LINES-1:0] pad_in,
  output logic [LINES-1:0] level_sync,
  output logic [LINES-1:0] level_filtered
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILTER_CYCLES - 1);

  logic [LINES-1:0] sync_first;

  // Two-flop synchroniser on every pad
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_first <= '0;
      level_sync <= '0;
    end else begin
      sync_first <= pad_in;
      level_sync <= sync_first;
    end
  end

  // Glitch filter: a new level is taken once it has stood long enough
  for (genvar i = 0; i < LINES; i++) begin : g_filter
    logic [CW-1:0] stable_cnt;
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        stable_cnt <= '0;
        level_filtered[i] <= 1'b0;
      end else if (level_sync[i] == level_filtered[i]) begin
        stable_cnt <= '0;
      end else if (stable_cnt == CNT_LAST) begin
        stable_cnt <= '0;
        level_filtered[i] <= level_sync[i];
      end else begin
        stable_cnt <= stable_cnt + 1'b1;
      end
    end
  end

endmodule

// [hw/gpio_line_control_status.sv]
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module gpio_line_control_status
  import gpio_line_pkg::*;
#(
  parameter int LINES = 32,
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEFAULT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire reg_req_t reg_req,
  output logic [31:0] rdata,
  input wire logic ctrl_clock_on,
  input wire logic [LINES-1:0] pad_in,
  output logic [LINES-1:0] pad_out,
  output logic [LINES-1:0] pad_oe,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter checks

  if (LINES < 1 || LINES > 32) begin : g_bad_lines
    $error("LINES must lie between 1 and 32");
  end
  if (FILTER_CYCLES < 1) begin : g_bad_filter
    $error("FILTER_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [LINES-1:0] output_enable;
  logic [LINES-1:0] filter_on;
  logic [LINES-1:0] output_data;
  logic [LINES-1:0] output_write;
  logic [LINES-1:0] pin_level;
  logic [LINES-1:0] irq_mask;
  logic [LINES-1:0] irq_status;
  logic [LINES-1:0] open_drain;
  logic [LINES-1:0] last_level;
  logic [LINES-1:0] level_sync;
  logic [LINES-1:0] level_filtered;
  logic [LINES-1:0] level_used;
  logic [LINES-1:0] change;
  logic [LINES-1:0] wd;
  logic [LINES-1:0] next_irq_status;
  logic [31:0] next_rdata;
  logic status_read;
  logic hit_drive_on;
  logic hit_drive_off;
  logic hit_filter_on;
  logic hit_filter_off;
  logic hit_data_set;
  logic hit_data_clear;
  logic hit_data_direct;
  logic hit_perm_on;
  logic hit_perm_off;
  logic hit_mask_on;
  logic hit_mask_off;
  logic hit_drain_on;
  logic hit_drain_off;
  logic [2:0] warm;

  // Zero-extend a line vector to a bus word
  function automatic logic [31:0] widen(input logic [LINES-1:0] v);
    logic [31:0] r;
    r = '0;
    r[LINES-1:0] = v;
    return r;
  endfunction

  assign wd = reg_req.wdata[LINES-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Write decode

  // One command strobe per offset, all low without a write
  always_comb begin
    hit_drive_on = 1'b0;
    hit_drive_off = 1'b0;
    hit_filter_on = 1'b0;
    hit_filter_off = 1'b0;
    hit_data_set = 1'b0;
    hit_data_clear = 1'b0;
    hit_data_direct = 1'b0;
    hit_perm_on = 1'b0;
    hit_perm_off = 1'b0;
    hit_mask_on = 1'b0;
    hit_mask_off = 1'b0;
    hit_drain_on = 1'b0;
    hit_drain_off = 1'b0;
    if (reg_req.wr) begin
      if (reg_req.addr == OFF_OUTPUT_ENABLE_CMD) begin
        hit_drive_on = 1'b1;
      end else if (reg_req.addr == OFF_OUTPUT_DISABLE_CMD) begin
        hit_drive_off = 1'b1;
      end else if (reg_req.addr == OFF_FILTER_ENABLE_CMD) begin
        hit_filter_on = 1'b1;
      end else if (reg_req.addr == OFF_FILTER_DISABLE_CMD) begin
        hit_filter_off = 1'b1;
      end else if (reg_req.addr == OFF_SET_OUTPUT_DATA_CMD) begin
        hit_data_set = 1'b1;
      end else if (reg_req.addr == OFF_CLEAR_OUTPUT_DATA_CMD) begin
        hit_data_clear = 1'b1;
      end else if (reg_req.addr == OFF_OUTPUT_DATA_STATUS) begin
        hit_data_direct = 1'b1;
      end else if (reg_req.addr == OFF_OUTPUT_WRITE_ENABLE_CMD) begin
        hit_perm_on = 1'b1;
      end else if (reg_req.addr == OFF_OUTPUT_WRITE_DISABLE_CMD) begin
        hit_perm_off = 1'b1;
      end else if (reg_req.addr == OFF_CHANGE_IRQ_ENABLE_CMD) begin
        hit_mask_on = 1'b1;
      end else if (reg_req.addr == OFF_CHANGE_IRQ_DISABLE_CMD) begin
        hit_mask_off = 1'b1;
      end else if (reg_req.addr == OFF_OPEN_DRAIN_ENABLE_CMD) begin
        hit_drain_on = 1'b1;
      end else if (reg_req.addr == OFF_OPEN_DRAIN_DISABLE_CMD) begin
        hit_drain_off = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input path

  line_input_stage #(
    .LINES(LINES),
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_input (
    .clock(clock),
    .arst_n(arst_n),
    .pad_in(pad_in),
    .level_sync(level_sync),
    .level_filtered(level_filtered)
  );

  // Filtered level on lines with the filter on, raw otherwise
  assign level_used = (level_filtered & filter_on) | (level_sync & ~filter_on);

  // Valid flags trailing the synchroniser, so reset gives no false edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      warm <= '0;
    end else begin
      warm <= {warm[1:0], 1'b1};
    end
  end

  // Changes count only once both compared levels are real
  assign change = (level_used ^ last_level) & {LINES{warm[2]}};

  ////////////////////////////////////////////////////////////////////////
  // Output driver enable

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      output_enable <= RST_OUTPUT_ENABLE[LINES-1:0];
    end else if (hit_drive_on) begin
      output_enable <= output_enable | wd;
    end else if (hit_drive_off) begin
      output_enable <= output_enable & ~wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Glitch filter selection

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      filter_on <= RST_FILTER[LINES-1:0];
    end else if (hit_filter_on) begin
      filter_on <= filter_on | wd;
    end else if (hit_filter_off) begin
      filter_on <= filter_on & ~wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output data: set, clear and permitted direct write

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      output_data <= RST_OUTPUT_DATA[LINES-1:0];
    end else if (hit_data_set) begin
      output_data <= output_data | wd;
    end else if (hit_data_clear) begin
      output_data <= output_data & ~wd;
    end else if (hit_data_direct) begin
      output_data <= (output_data & ~output_write)
                   | (wd & output_write);
    end
  end

  // Direct-write permission per line
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      output_write <= RST_OUTPUT_WRITE[LINES-1:0];
    end else if (hit_perm_on) begin
      output_write <= output_write | wd;
    end else if (hit_perm_off) begin
      output_write <= output_write & ~wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain selection

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      open_drain <= RST_OPEN_DRAIN[LINES-1:0];
    end else if (hit_drain_on) begin
      open_drain <= open_drain | wd;
    end else if (hit_drain_off) begin
      open_drain <= open_drain & ~wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad drive, registered

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pad_out <= '0;
      pad_oe <= '0;
    end else begin
      pad_out <= output_data & ~open_drain;
      pad_oe <= output_enable & ~(open_drain & output_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin level capture, frozen while the controller clock is off

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_level <= RST_PIN_LEVEL[LINES-1:0];
    end else if (ctrl_clock_on) begin
      pin_level <= level_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Change interrupt mask

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask <= RST_CHANGE_IRQ_MASK[LINES-1:0];
    end else if (hit_mask_on) begin
      irq_mask <= irq_mask | wd;
    end else if (hit_mask_off) begin
      irq_mask <= irq_mask & ~wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Change detection and sticky status

  assign status_read = reg_req.rd && (reg_req.addr == OFF_CHANGE_IRQ_STATUS);

  // A change in the clearing cycle survives the clear
  always_comb begin
    next_irq_status = irq_status;
    if (status_read) begin
      next_irq_status = '0;
    end
    next_irq_status = next_irq_status | change;
  end

  // Previous level follows the live level, reset to the reset level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last_level <= '0;
    end else begin
      last_level <= level_used;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= RST_CHANGE_IRQ_STATUS[LINES-1:0];
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Interrupt line from pending and enabled lines
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read decode

  always_comb begin
    if (reg_req.addr == OFF_OUTPUT_ENABLE_STATUS) begin
      next_rdata = widen(output_enable);
    end else if (reg_req.addr == OFF_FILTER_STATUS) begin
      next_rdata = widen(filter_on);
    end else if (reg_req.addr == OFF_OUTPUT_DATA_STATUS) begin
      next_rdata = widen(output_data);
    end else if (reg_req.addr == OFF_PIN_LEVEL_STATUS) begin
      next_rdata = widen(pin_level);
    end else if (reg_req.addr == OFF_CHANGE_IRQ_MASK) begin
      next_rdata = widen(irq_mask);
    end else if (reg_req.addr == OFF_CHANGE_IRQ_STATUS) begin
      next_rdata = widen(irq_status);
    end else if (reg_req.addr == OFF_OPEN_DRAIN_STATUS) begin
      next_rdata = widen(open_drain);
    end else if (reg_req.addr == OFF_OUTPUT_WRITE_PERMISSION) begin
      next_rdata = widen(output_write);
    end else begin
      next_rdata = READ_UNMAPPED;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (reg_req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

endmodule

// [verif/gpio_line_control_status_sva.sv]
`timescale 1ns/1ps
module gpio_line_control_status_sva
  import gpio_line_pkg::*;
#(
  parameter int LINES = 32
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire reg_req_t reg_req,
  input wire logic [31:0] rdata,
  input wire logic ctrl_clock_on,
  input wire logic [LINES-1:0] pad_in,
  input wire logic [LINES-1:0] pad_out,
  input wire logic [LINES-1:0] pad_oe,
  input wire logic irq
);
  logic [LINES-1:0] wd;
  logic [LINES-1:0] prev_pad;
  logic [LINES-1:0] held;
  logic [3:0] quiet;
  logic held_ok;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  assign wd = reg_req.wdata[LINES-1:0];
  ////////////////////////////////////////////////////////////////////////
  // Counts cycles of steady pads with the clock on
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_pad <= '0;
      quiet <= '0;
    end else begin
      prev_pad <= pad_in;
      if (pad_in != prev_pad || !ctrl_clock_on) begin
        quiet <= '0;
      end else if (quiet != 4'hf) begin
        quiet <= quiet + 4'h1;
      end
    end
  end
  // Pad levels seen last while the clock was on
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      held <= '0;
      held_ok <= 1'b0;
    end else if (ctrl_clock_on) begin
      held <= pad_in;
      held_ok <= quiet > 4'h3 && pad_in == prev_pad;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_set_drives: assert property (
    reg_req.wr && reg_req.addr == OFF_SET_OUTPUT_DATA_CMD ##1 !reg_req.wr
    |=> ($past(wd, 2) & pad_oe & ~pad_out) == '0)
    else $error("set line not driven high");
  a_clear_drives: assert property (
    reg_req.wr && reg_req.addr == OFF_CLEAR_OUTPUT_DATA_CMD ##1 !reg_req.wr
    |=> ($past(wd, 2) & pad_out) == '0)
    else $error("cleared line still high");
  a_disable_driver: assert property (
    reg_req.wr && reg_req.addr == OFF_OUTPUT_DISABLE_CMD ##1 !reg_req.wr
    |=> ($past(wd, 2) & pad_oe) == '0)
    else $error("disabled line still driven");
  a_drain_no_high: assert property (
    reg_req.wr && reg_req.addr == OFF_OPEN_DRAIN_ENABLE_CMD ##1 !reg_req.wr
    |=> ($past(wd, 2) & pad_out) == '0)
    else $error("open drain line driven high");
  a_cmd_reads_zero: assert property (
    reg_req.rd && !reg_req.addr[3] |=> rdata == '0)
    else $error("command offset read not zero");
  a_irq_clear: assert property (
    reg_req.rd && reg_req.addr == OFF_CHANGE_IRQ_STATUS && quiet == 4'hf
    |=> ##1 !irq)
    else $error("irq stays after status read");
  a_pin_level: assert property (
    reg_req.rd && reg_req.addr == OFF_PIN_LEVEL_STATUS && quiet > 4'h3
    && pad_in == prev_pad |=> rdata[LINES-1:0] == $past(pad_in))
    else $error("pin level view wrong");
  a_pin_frozen: assert property (
    reg_req.rd && reg_req.addr == OFF_PIN_LEVEL_STATUS && !ctrl_clock_on
    && held_ok |=> rdata[LINES-1:0] == held)
    else $error("pin level view not frozen");
endmodule

bind gpio_line_control_status gpio_line_control_status_sva #(
  .LINES(LINES)
) chk_u (
  .clock(clock),
  .arst_n(arst_n),
  .reg_req(reg_req),
  .rdata(rdata),
  .ctrl_clock_on(ctrl_clock_on),
  .pad_in(pad_in),
  .pad_out(pad_out),
  .pad_oe(pad_oe),
  .irq(irq)
);

// [verif/pad_model.sv]
`timescale 1ns/1ps
module pad_model (
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  output logic [31:0] pad_in
);
  // Chip driver first, then outside driver, else board pull-up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en);
endmodule

// [verif/gpio_line_control_status_test.sv]
`timescale 1ns/1ps
module gpio_line_control_status_test;
  import gpio_line_pkg::*;
  logic clock;
  logic arst_n;
  reg_req_t reg_req;
  logic [31:0] rdata;
  logic ctrl_clock_on;
  logic [31:0] pad_in;
  logic [31:0] pad_out;
  logic [31:0] pad_oe;
  logic irq;
  logic [31:0] ext_en;
  logic [31:0] ext_val;
  logic [31:0] v;
  int failures;
  int checks_done;
  gpio_line_control_status dut_u (
    .clock(clock),
    .arst_n(arst_n),
    .reg_req(reg_req),
    .rdata(rdata),
    .ctrl_clock_on(ctrl_clock_on),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .irq(irq)
  );
  pad_model pads_u (
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .ext_en(ext_en),
    .ext_val(ext_val),
    .pad_in(pad_in)
  );
  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    reg_req <= '0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock);
    reg_req <= '0;
    #1 d = rdata;
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset_values;
    logic [7:0] offs [6];
    offs = '{OFF_OUTPUT_ENABLE_STATUS, OFF_FILTER_STATUS,
      OFF_OUTPUT_DATA_STATUS, OFF_CHANGE_IRQ_MASK, OFF_OPEN_DRAIN_STATUS,
      OFF_OUTPUT_WRITE_PERMISSION};
    foreach (offs[i]) begin
      rd(offs[i], v);
      check(v, 32'h0000_0000);
    end
    rd(8'hfc, v);
    check(v, READ_UNMAPPED);
  endtask
  task t_output;
    wr(OFF_OUTPUT_ENABLE_CMD, 32'h0000_00ff);
    wr(OFF_OUTPUT_DISABLE_CMD, 32'h0000_000f);
    wr(OFF_OUTPUT_ENABLE_STATUS, 32'hffff_ffff);
    rd(OFF_OUTPUT_ENABLE_STATUS, v);
    check(v, 32'h0000_00f0);
    wr(OFF_SET_OUTPUT_DATA_CMD, 32'h0000_00f0);
    rd(OFF_SET_OUTPUT_DATA_CMD, v);
    check(v, 32'h0000_0000);
    wr(OFF_CLEAR_OUTPUT_DATA_CMD, 32'h0000_0030);
    wr(OFF_OUTPUT_DATA_STATUS, 32'hffff_ffff);
    rd(OFF_OUTPUT_DATA_STATUS, v);
    check(v, 32'h0000_00c0);
    check(pad_out, 32'h0000_00c0);
    wr(OFF_OUTPUT_WRITE_ENABLE_CMD, 32'h0000_0001);
    wr(OFF_OUTPUT_DATA_STATUS, 32'hffff_ff01);
    rd(OFF_OUTPUT_DATA_STATUS, v);
    check(v, 32'h0000_00c1);
    wr(OFF_OUTPUT_WRITE_DISABLE_CMD, 32'h0000_0001);
    wr(OFF_OUTPUT_DATA_STATUS, 32'h0000_0000);
    rd(OFF_OUTPUT_DATA_STATUS, v);
    check(v, 32'h0000_00c1);
  endtask
  task t_open_drain;
    wr(OFF_OPEN_DRAIN_ENABLE_CMD, 32'h0000_0080);
    rd(OFF_OPEN_DRAIN_STATUS, v);
    check(v, 32'h0000_0080);
    check(pad_oe, 32'h0000_0070);
    check(pad_out, 32'h0000_0041);
    wr(OFF_CLEAR_OUTPUT_DATA_CMD, 32'h0000_0080);
    rd(OFF_OPEN_DRAIN_STATUS, v);
    check(pad_oe, 32'h0000_00f0);
    wr(OFF_OPEN_DRAIN_DISABLE_CMD, 32'h0000_0080);
    rd(OFF_OPEN_DRAIN_STATUS, v);
    check(v, 32'h0000_0000);
  endtask
  task t_filter;
    wr(OFF_FILTER_ENABLE_CMD, 32'h0000_0300);
    wr(OFF_FILTER_DISABLE_CMD, 32'h0000_0100);
    rd(OFF_FILTER_STATUS, v);
    check(v, 32'h0000_0200);
    // One-cycle low pulse: kept on the raw line, dropped on the filtered one
    rd(OFF_CHANGE_IRQ_STATUS, v);
    ext_en <= 32'h0000_0300;
    @(posedge clock);
    ext_en <= 32'h0000_0000;
    repeat (8) @(posedge clock);
    rd(OFF_CHANGE_IRQ_STATUS, v);
    check(v, 32'h0000_0100);
  endtask
  task t_irq;
    int n;
    repeat (8) @(posedge clock);
    rd(OFF_CHANGE_IRQ_STATUS, v);
    wr(OFF_CHANGE_IRQ_ENABLE_CMD, 32'h0000_0100);
    rd(OFF_CHANGE_IRQ_MASK, v);
    check(v, 32'h0000_0100);
    ext_en <= 32'h0000_0100;
    for (n = 0; n < 20 && irq !== 1'b1; n++) @(posedge clock);
    check(irq, 1'b1);
    repeat (16) @(posedge clock);
    rd(OFF_CHANGE_IRQ_STATUS, v);
    check(v, 32'h0000_0100);
    rd(OFF_CHANGE_IRQ_STATUS, v);
    check(v, 32'h0000_0000);
    check(irq, 1'b0);
    wr(OFF_CHANGE_IRQ_DISABLE_CMD, 32'h0000_0100);
    ext_en <= '0;
    repeat (10) @(posedge clock);
    check(irq, 1'b0);
    rd(OFF_CHANGE_IRQ_STATUS, v);
    check(v, 32'h0000_0100);
  endtask
  task t_freeze;
    repeat (8) @(posedge clock);
    ctrl_clock_on <= 1'b0;
    ext_en <= 32'h0000_0200;
    repeat (6) @(posedge clock);
    rd(OFF_PIN_LEVEL_STATUS, v);
    check(v[9], 1'b1);
    ctrl_clock_on <= 1'b1;
    repeat (8) @(posedge clock);
    rd(OFF_PIN_LEVEL_STATUS, v);
    check(v[9], 1'b0);
  endtask
  task t_reset_again;
    ext_en <= '0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    rd(OFF_CHANGE_IRQ_STATUS, v);
    check(v, 32'h0000_0000);
    rd(OFF_PIN_LEVEL_STATUS, v);
    check(v, 32'hffff_ffff);
    rd(OFF_OUTPUT_DATA_STATUS, v);
    check(v, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    arst_n = 1'b0;
    reg_req = '0;
    ctrl_clock_on = 1'b1;
    ext_en = '0;
    ext_val = '0;
    failures = 0;
    checks_done = 0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    t_reset_values;
    t_output;
    t_open_drain;
    t_filter;
    t_irq;
    t_freeze;
    t_reset_again;
    end_of_test;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    end_of_test;
  end
endmodule
